//--- core/cmc_bus_watch.sv
// Receive pin synchroniser, bus idle detector and wake-up filter.
// Assumes bitTick is a one-cycle pulse per nominal bit from bit timing.
`timescale 1ns/1ps
`default_nettype none
module cmc_bus_watch
  import cmc_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   arst_n,
  input  wire logic   clk_en,
  input  wire logic   rxPin,
  cmc_watch_if.watch  w
);

  logic       rxMeta;
  logic       rxS2;
  logic       rxS3;
  logic       rxLevel;
  logic [3:0] idleCount;
  logic [7:0] lowCount;
  logic       dominant;
  logic       dominantQ;
  logic       wakeEvent;

  // Three-stage synchroniser, change accepted once stages two and three agree
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rxMeta  <= 1'b1;
      rxS2    <= 1'b1;
      rxS3    <= 1'b1;
      rxLevel <= 1'b1;
    end
    else if (clk_en)
    begin
      rxMeta <= rxPin;
      rxS2   <= rxMeta;
      rxS3   <= rxS2;
      if (rxS2 == rxS3)
        rxLevel <= rxS3;
    end
  end

  // Consecutive recessive bit counter
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      idleCount <= 4'h0;
    else if (clk_en && w.bitTick)
    begin
      if (!rxLevel)
        idleCount <= 4'h0;
      else if (idleCount < IDLE_BITS)
        idleCount <= idleCount + 4'h1;
    end
  end

  // Low-pass filter on dominant level while asleep
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      lowCount <= 8'h00;
    else if (clk_en)
    begin
      if (rxLevel)
        lowCount <= 8'h00;
      else if (lowCount < WAKE_FILTER_CYCLES)
        lowCount <= lowCount + 8'h01;
    end
  end

  assign dominant = w.filterEn ? (lowCount == WAKE_FILTER_CYCLES) : !rxLevel;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dominantQ <= 1'b0;
      wakeEvent <= 1'b0;
    end
    else if (clk_en)
    begin
      dominantQ <= dominant;
      wakeEvent <= dominant && !dominantQ;
    end
  end

  assign w.rxLevel   = rxLevel;
  assign w.busIdle   = (idleCount == IDLE_BITS);
  assign w.wakeEvent = wakeEvent;

endmodule : cmc_bus_watch
`default_nettype wire

//--- core/cmc_mode_control_unit.sv
// Mode controller and control/status registers of a CAN controller.
// Assumes an AXI4-Lite master, a frame engine and buffers on core_clk.
`timescale 1ns/1ps
`default_nettype none
module cmc_mode_control_unit
  import cmc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rxPin,
  output logic             txPinOut,
  output logic             txPinOe_n,
  output logic             rxPinOwned,
  input  wire logic        bitTick,
  input  wire logic        cpuIdle,
  input  wire logic        cpuSleep,
  input  wire logic        engineTx,
  output logic             engineRx,
  input  wire logic        txBusy,
  input  wire logic        txPending,
  input  wire logic        allAborted,
  input  wire logic        msgReceived,
  input  wire logic [4:0]  filterHit,
  input  wire logic        filterHitValid,
  input  wire logic [15:0] bufIrq,
  input  wire logic        errIrq,
  input  wire logic        wakeIrq,
  input  wire logic        ovfIrq,
  input  wire logic        fifoIrq,
  output logic             txEnable,
  output logic             rxEnable,
  output logic             ackEnable,
  output logic             errCountEnable,
  output logic             errCountClear,
  output logic             listenAll,
  output logic             txStartAllow,
  output logic             txAbortWaiting,
  output logic             abortAll,
  output logic             moduleHalt,
  output logic             captureEvent,
  output logic             windowSelect,
  output logic             wakeupEvent,
  output logic [4:0]       netFilterBits,
  output logic             netFilterValid,
  output logic             cfgWriteEnable
);

  cmc_watch_if watch ();

  cmc_switch_e swState;
  cmc_mode_e   opMode;
  logic [2:0]  reqMode;
  logic        stopInIdle;
  logic        captureEn;
  logic        wakeFilterEn;
  logic [4:0]  netCount;
  logic [4:0]  filterHitNum;
  logic [6:0]  intCode;
  logic [6:0]  next_intCode;
  logic        idleSinceEntry;
  logic        reqValid;
  logic        wantSwitch;
  logic        enterOk;
  logic        inConfig;
  logic        sleeping;
  logic        wrFire;
  logic        rdFire;
  logic [1:0]  wrResp;
  logic [15:0] wrData;
  logic [15:0] ctrlRead;
  logic [15:0] rdWord;
  logic [1:0]  rdResp;

  cmc_bus_watch u_watch (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .rxPin    (rxPin),
    .w        (watch.watch)
  );

  assign inConfig       = (opMode == MODE_CONFIG);
  assign sleeping       = cpuSleep || (opMode == MODE_DISABLE);
  assign watch.filterEn = wakeFilterEn && sleeping;
  assign watch.bitTick  = bitTick;

  // Mode request handling
  assign reqValid   = (reqMode != MODE_RSV5) && (reqMode != MODE_RSV6);
  assign wantSwitch = reqValid && (reqMode != opMode);
  assign enterOk    = watch.busIdle && !((reqMode == MODE_CONFIG) && txBusy);

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      swState <= SW_STEADY;
      opMode  <= MODE_RESET;
    end
    else if (clk_en && !moduleHalt)
    begin
      case (swState)
        SW_STEADY:
        begin
          if (wantSwitch)
            swState <= SW_WAIT;
        end
        SW_WAIT:
        begin
          if (!wantSwitch)
            swState <= SW_STEADY;
          else if (enterOk)
          begin
            opMode  <= cmc_mode_e'(reqMode);
            swState <= SW_STEADY;
          end
        end
        default:
          swState <= SW_STEADY;
      endcase
    end
  end

  // Error counters cleared on entry to configuration mode
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      errCountClear <= 1'b0;
    else if (clk_en)
      errCountClear <= !moduleHalt && (swState == SW_WAIT) && wantSwitch && enterOk
                       && (reqMode == MODE_CONFIG);
  end

  // Idle seen since the latest mode entry gates the first transmission
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      idleSinceEntry <= 1'b0;
    else if (clk_en)
    begin
      if (!moduleHalt && (swState == SW_WAIT) && wantSwitch && enterOk)
        idleSinceEntry <= 1'b0;
      else if (watch.busIdle)
        idleSinceEntry <= 1'b1;
    end
  end

  assign txStartAllow = txEnable && idleSinceEntry && !moduleHalt;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      txAbortWaiting <= 1'b0;
    else if (clk_en)
      txAbortWaiting <= txEnable && txPending && !idleSinceEntry
                        && (reqMode == MODE_DISABLE);
  end

  // Engine permissions per mode
  assign txEnable       = (opMode == MODE_NORMAL) || (opMode == MODE_LOOPBACK);
  assign rxEnable       = (opMode == MODE_NORMAL) || (opMode == MODE_LOOPBACK)
                          || (opMode == MODE_LISTEN_ONLY) || (opMode == MODE_LISTEN_ALL);
  assign ackEnable      = txEnable;
  assign errCountEnable = txEnable;
  assign listenAll      = (opMode == MODE_LISTEN_ALL);
  assign cfgWriteEnable = inConfig;

  // Pin ownership and loopback routing
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      txPinOut   <= 1'b1;
      txPinOe_n  <= 1'b1;
      rxPinOwned <= 1'b0;
      engineRx   <= 1'b1;
    end
    else if (clk_en)
    begin
      txPinOut   <= (opMode == MODE_NORMAL) ? engineTx : 1'b1;
      txPinOe_n  <= (opMode != MODE_NORMAL);
      rxPinOwned <= (opMode == MODE_NORMAL) || (opMode == MODE_LISTEN_ONLY)
                    || (opMode == MODE_LISTEN_ALL);
      if (opMode == MODE_LOOPBACK)
        engineRx <= engineTx;
      else if (rxEnable)
        engineRx <= watch.rxLevel;
      else
        engineRx <= 1'b1;
    end
  end

  // Halt, capture and wake-up events
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      moduleHalt   <= 1'b0;
      captureEvent <= 1'b0;
      wakeupEvent  <= 1'b0;
    end
    else if (clk_en)
    begin
      moduleHalt   <= stopInIdle && cpuIdle;
      captureEvent <= captureEn && msgReceived;
      wakeupEvent  <= watch.wakeEvent && sleeping;
    end
  end

  // Network address filter count
  assign netFilterBits  = netCount;
  assign netFilterValid = (netCount <= NETCNT_MAX);

  // Filter hit capture
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      filterHitNum <= 5'h00;
    else if (clk_en && filterHitValid && (filterHit <= FILTER_MAX))
      filterHitNum <= filterHit;
  end

  // Interrupt code: error, wake-up, buffers 0..15, overflow, FIFO
  always_comb
  begin
    next_intCode = ICODE_NONE;
    if (errIrq)
      next_intCode = ICODE_ERROR;
    else if (wakeIrq)
      next_intCode = ICODE_WAKE;
    else if (|bufIrq)
    begin
      for (int i = 15; i >= 0; i--)
      begin
        if (bufIrq[i])
          next_intCode = 7'(i);
      end
    end
    else if (ovfIrq)
      next_intCode = ICODE_OVERRUN;
    else if (fifoIrq)
      next_intCode = ICODE_FIFO;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      intCode <= ICODE_NONE;
    else if (clk_en)
      intCode <= next_intCode;
  end

  // AXI4-Lite write channel: address and data taken together
  assign s_axi_awready = s_axi_wvalid && !s_axi_bvalid && clk_en;
  assign s_axi_wready  = s_axi_awvalid && !s_axi_bvalid && clk_en;
  assign wrFire        = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && clk_en;
  assign wrData        = s_axi_wdata[15:0];

  always_comb
  begin
    case (s_axi_awaddr)
      ADDR_MODE_CTRL: wrResp = RESP_OKAY;
      ADDR_NETFILT:   wrResp = inConfig ? RESP_OKAY : RESP_SLVERR;
      ADDR_TIMING2:   wrResp = inConfig ? RESP_OKAY : RESP_SLVERR;
      ADDR_INTCODE:   wrResp = RESP_SLVERR;
      default:        wrResp = RESP_DECERR;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (wrFire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrResp;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Control register fields
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reqMode      <= MODE_RESET;
      stopInIdle   <= 1'b0;
      captureEn    <= 1'b0;
      windowSelect <= 1'b0;
      netCount     <= 5'h00;
      wakeFilterEn <= 1'b0;
    end
    else if (wrFire)
    begin
      if (s_axi_awaddr == ADDR_MODE_CTRL)
      begin
        if (s_axi_wstrb[1])
          reqMode <= wrData[CTRL_REQ_LSB +: 3];
        if (s_axi_wstrb[1] && inConfig)
          stopInIdle <= wrData[CTRL_STOPIDLE_BIT];
        if (s_axi_wstrb[0] && inConfig)
          captureEn <= wrData[CTRL_CAPTURE_BIT];
        if (s_axi_wstrb[0])
          windowSelect <= wrData[CTRL_WINDOW_BIT];
      end
      if ((s_axi_awaddr == ADDR_NETFILT) && inConfig && s_axi_wstrb[0])
        netCount <= wrData[4:0];
      if ((s_axi_awaddr == ADDR_TIMING2) && inConfig && s_axi_wstrb[1])
        wakeFilterEn <= wrData[TIM2_WAKEFIL_BIT];
    end
  end

  // Abort-all: a software set in the same cycle wins over the self-clear
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      abortAll <= 1'b0;
    else if (clk_en)
    begin
      if (wrFire && (s_axi_awaddr == ADDR_MODE_CTRL) && s_axi_wstrb[1]
          && wrData[CTRL_ABORT_BIT])
        abortAll <= 1'b1;
      else if (allAborted)
        abortAll <= 1'b0;
    end
  end

  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid && clk_en;
  assign rdFire        = s_axi_arvalid && !s_axi_rvalid && clk_en;

  always_comb
  begin
    ctrlRead                        = 16'h0000;
    ctrlRead[CTRL_STOPIDLE_BIT]     = stopInIdle;
    ctrlRead[CTRL_ABORT_BIT]        = abortAll;
    ctrlRead[CTRL_REQ_LSB +: 3]     = reqMode;
    ctrlRead[CTRL_STAT_LSB +: 3]    = opMode;
    ctrlRead[CTRL_CAPTURE_BIT]      = captureEn;
    ctrlRead[CTRL_WINDOW_BIT]       = windowSelect;
    rdResp                          = RESP_OKAY;
    case (s_axi_araddr)
      ADDR_MODE_CTRL: rdWord = ctrlRead;
      ADDR_NETFILT:   rdWord = {11'h000, netCount};
      ADDR_INTCODE:   rdWord = {3'h0, filterHitNum, 1'b0, intCode};
      ADDR_TIMING2:   rdWord = {1'b0, wakeFilterEn, 14'h0000};
      default:
      begin
        rdWord = 16'h0000;
        rdResp = RESP_DECERR;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (rdFire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, rdWord};
        s_axi_rresp  <= rdResp;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule : cmc_mode_control_unit
`default_nettype wire

//--- core/cmc_pkg.sv
// Shared constants and types of the CAN mode control unit.
// Assumes a 40 MHz core clock and an AXI4-Lite master with 32-bit data.
package cmc_pkg;

  // Register byte addresses
  localparam logic [11:0] ADDR_MODE_CTRL = 12'h000;
  localparam logic [11:0] ADDR_NETFILT   = 12'h004;
  localparam logic [11:0] ADDR_INTCODE   = 12'h008;
  localparam logic [11:0] ADDR_TIMING2   = 12'h00C;

  // Field positions
  localparam int CTRL_STOPIDLE_BIT = 13;
  localparam int CTRL_ABORT_BIT    = 12;
  localparam int CTRL_REQ_LSB      = 8;
  localparam int CTRL_STAT_LSB     = 5;
  localparam int CTRL_CAPTURE_BIT  = 3;
  localparam int CTRL_WINDOW_BIT   = 0;
  localparam int TIM2_WAKEFIL_BIT  = 14;
  localparam int VEC_HIT_LSB       = 8;

  typedef enum logic [2:0] {
    MODE_NORMAL      = 3'h0,
    MODE_DISABLE     = 3'h1,
    MODE_LOOPBACK    = 3'h2,
    MODE_LISTEN_ONLY = 3'h3,
    MODE_CONFIG      = 3'h4,
    MODE_RSV5        = 3'h5,
    MODE_RSV6        = 3'h6,
    MODE_LISTEN_ALL  = 3'h7
  } cmc_mode_e;

  typedef enum logic {
    SW_STEADY = 1'b0,
    SW_WAIT   = 1'b1
  } cmc_switch_e;

  // Reset values and interrupt codes
  localparam cmc_mode_e  MODE_RESET    = MODE_CONFIG;
  localparam logic [6:0] ICODE_NONE    = 7'h40;
  localparam logic [6:0] ICODE_ERROR   = 7'h41;
  localparam logic [6:0] ICODE_WAKE    = 7'h42;
  localparam logic [6:0] ICODE_OVERRUN = 7'h43;
  localparam logic [6:0] ICODE_FIFO    = 7'h44;

  localparam logic [4:0] NETCNT_MAX    = 5'h11;
  localparam logic [4:0] FILTER_MAX    = 5'h0F;
  localparam logic [3:0] IDLE_BITS     = 4'hB;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Wake-up low-pass filter: least dominant time that counts as activity
  localparam int CLK_PERIOD_NS  = 25;
  localparam int WAKE_FILTER_NS = 250;
  localparam logic [7:0] WAKE_FILTER_CYCLES =
    8'((WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage : cmc_pkg

//--- core/cmc_watch_if.sv
// Bundle between the mode controller and the bus receive watcher.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
`default_nettype none
interface cmc_watch_if;
  logic rxLevel;
  logic busIdle;
  logic wakeEvent;
  logic filterEn;
  logic bitTick;

  modport watch (input filterEn, input bitTick, output rxLevel, output busIdle, output wakeEvent);
  modport ctrl  (output filterEn, output bitTick, input rxLevel, input busIdle, input wakeEvent);
endinterface : cmc_watch_if
`default_nettype wire

//--- verification/cmc_can_node.sv
// Other nodes on the CAN bus: bit pacing and dominant frame bits.
// Assumes a wired-AND bus, recessive high through a pull-up.
`timescale 1ns/1ps
`default_nettype none
module cmc_can_node
(
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       frameGo,
  input  wire logic [7:0] frameLen,
  output logic            bitTick,
  output logic            busDrive
);
  logic [1:0] phase;
  logic [7:0] left;

  // One bit time is four clocks
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      phase <= 2'h0;
    else
      phase <= phase + 2'h1;

  assign bitTick = (phase == 2'h3);

  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      left <= 8'h0;
    else if (frameGo)
      left <= frameLen;
    else if (bitTick && left != 8'h0)
      left <= left - 8'h1;

  // Dominant every other bit, so no idle gap inside a frame
  assign busDrive = (left == 8'h0) | left[0];
endmodule : cmc_can_node
`default_nettype wire

//--- verification/cmc_mode_control_assertions.sv
// Concurrent checks on the ports of the CAN mode control unit.
// Assumes one clock domain, core_clk, with arst_n as its reset.
`timescale 1ns/1ps
`default_nettype none
module cmc_mode_control_assertions
(
  input wire logic       core_clk,
  input wire logic       arst_n,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       txPinOe_n,
  input wire logic       txEnable,
  input wire logic       rxEnable,
  input wire logic       ackEnable,
  input wire logic       listenAll,
  input wire logic       cfgWriteEnable,
  input wire logic       errCountClear,
  input wire logic       abortAll,
  input wire logic       allAborted,
  input wire logic       captureEvent,
  input wire logic       msgReceived,
  input wire logic       txStartAllow,
  input wire logic       moduleHalt,
  input wire logic       txAbortWaiting,
  input wire logic       txPending,
  input wire logic [4:0] netFilterBits,
  input wire logic       netFilterValid
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  resp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  tx_owner_a: assert property (!txPinOe_n |-> $past(txEnable))
    else $error("tx pin driven outside normal mode");
  cfg_clear_a: assert property ($rose(cfgWriteEnable) |-> ##[0:1] errCountClear)
    else $error("error counters not cleared on config entry");
  cfg_quiet_a: assert property (cfgWriteEnable |-> !txEnable && !rxEnable)
    else $error("traffic enabled in config mode");
  listen_all_a: assert property (listenAll |-> !txEnable && !ackEnable)
    else $error("listen-all mode sends on the bus");
  abort_clear_a: assert property ($fell(abortAll) |-> $past(allAborted))
    else $error("abort-all cleared before all aborted");
  capture_src_a: assert property (captureEvent |-> $past(msgReceived))
    else $error("capture event without a received message");
  tx_start_a: assert property (txStartAllow |-> txEnable && !moduleHalt)
    else $error("transmit start allowed in wrong state");
  tx_abort_a: assert property (txAbortWaiting |-> $past(txEnable) && $past(txPending))
    else $error("abort of waiting transmit without one pending");
  net_valid_a: assert property (netFilterValid == (netFilterBits <= 5'h11))
    else $error("network filter validity wrong");
endmodule : cmc_mode_control_assertions

bind cmc_mode_control_unit cmc_mode_control_assertions u_cmc_mode_control_assertions (.*);
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench of the CAN mode control unit over AXI4-Lite.
// Assumes the bus node model drives the wired-AND receive line.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import cmc_pkg::*;
;
  logic core_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, cpuSleep = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, frameGo = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic cpuIdle = 1'b0, engineTx = 1'b1, txBusy = 1'b0, txPending = 1'b0;
  logic allAborted = 1'b0, msgReceived = 1'b0, filterHitValid = 1'b0;
  logic errIrq = 1'b0, wakeIrq = 1'b0, ovfIrq = 1'b0, fifoIrq = 1'b0;
  logic [4:0] filterHit = 5'h0, netFilterBits, v;
  logic [15:0] bufIrq = 16'h0, b;
  logic [7:0] frameLen = 8'h0;
  logic rxPin, txPinOut, txPinOe_n, rxPinOwned, bitTick, busDrive, engineRx;
  logic txEnable, rxEnable, ackEnable, errCountEnable, errCountClear, listenAll;
  logic txStartAllow, txAbortWaiting, abortAll, moduleHalt, captureEvent;
  logic windowSelect, wakeupEvent, netFilterValid, cfgWriteEnable;
  logic sidl, abt, cap, window_select_bit;
  logic [2:0] req, stat;
  logic [2:0] codes [4] = '{3'h1, 3'h2, 3'h3, 3'h7};
  logic [3:0] f;
  logic [6:0] ic;
  logic [31:0] seed, r;
  logic [33:0] got, expQ[$];
  int mismatches = 0, checks = 0, wakes = 0, i, j;

  cmc_mode_control_unit u_cmc_mode_control_unit (.*);
  cmc_can_node u_cmc_can_node (.*);

  assign rxPin = busDrive & (txPinOe_n | txPinOut);

  always #12.5 core_clk = ~core_clk;

  task automatic finish_test();
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0 && expQ.size() == 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    checks++;
    if (seen !== want)
    begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic tick(inout int n);
    @(posedge core_clk);
    n++;
    if (n > 200)
    begin
      mismatches++;
      finish_test();
    end
  endtask : tick

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] rs);
    int n;
    n = 0;
    expQ.push_back({rs, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do tick(n); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do tick(n); while (!s_axi_bvalid);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    int n;
    n = 0;
    expQ.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do tick(n); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do tick(n); while (!s_axi_rvalid);
  endtask : rd

  function automatic logic [31:0] modeWord();
    return {18'h0, sidl, abt, 1'b0, req, stat, 1'b0, cap, 2'h0, window_select_bit};
  endfunction : modeWord

  task automatic setMode(input logic [2:0] code);
    req = code;
    wr(ADDR_MODE_CTRL, modeWord(), RESP_OKAY);
    repeat (60) @(posedge core_clk);
    stat = code;
    rd(ADDR_MODE_CTRL, {RESP_OKAY, modeWord()});
  endtask : setMode

  // Bus results are compared in the order they were requested
  always @(posedge core_clk)
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
    begin
      got = s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
      check(got, expQ.pop_front());
    end

  // Wake-up pulses counted as they appear
  always @(posedge core_clk)
    if (wakeupEvent)
      wakes++;

  initial
  begin
    seed = 32'hDACFB1B2;
    {sidl, abt, cap, window_select_bit} = 4'h0;
    req = 3'h4;
    stat = 3'h4;
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    rd(ADDR_MODE_CTRL, {RESP_OKAY, modeWord()});
    rd(ADDR_INTCODE, {RESP_OKAY, 25'h0, ICODE_NONE});
    rd(12'h010, {RESP_DECERR, 32'h0});
    for (i = 0; i < 4; i++)
    begin
      v = 5'($random(seed));
      wr(ADDR_NETFILT, {27'h0, v}, RESP_OKAY);
      rd(ADDR_NETFILT, {RESP_OKAY, 27'h0, v});
    end
    {sidl, cap, window_select_bit} = 3'h7;
    wr(ADDR_MODE_CTRL, modeWord(), RESP_OKAY);
    rd(ADDR_MODE_CTRL, {RESP_OKAY, modeWord()});
    check({33'h0, windowSelect}, 34'h1);
    cpuIdle <= 1'b1;
    repeat (3) @(posedge core_clk);
    check({33'h0, moduleHalt}, 34'h1);
    cpuIdle <= 1'b0;
    repeat (3) @(posedge core_clk);
    check({33'h0, moduleHalt}, 34'h0);
    abt = 1'b1;
    wr(ADDR_MODE_CTRL, modeWord(), RESP_OKAY);
    rd(ADDR_MODE_CTRL, {RESP_OKAY, modeWord()});
    allAborted <= 1'b1;
    @(posedge core_clk);
    allAborted <= 1'b0;
    abt = 1'b0;
    rd(ADDR_MODE_CTRL, {RESP_OKAY, modeWord()});
    for (i = 0; i < 8; i++)
    begin
      r = $random(seed);
      b = (i < 4) ? 16'h0 : r[31:16];
      f = r[3:0] & {i[0], i[1], 2'h3};
      bufIrq <= b;
      {errIrq, wakeIrq, ovfIrq, fifoIrq} <= f;
      filterHit <= {1'b0, r[11:8]};
      filterHitValid <= 1'b1;
      msgReceived <= 1'b1;
      @(posedge core_clk);
      filterHitValid <= 1'b0;
      msgReceived <= 1'b0;
      ic = f[0] ? ICODE_FIFO : ICODE_NONE;
      if (f[1])
        ic = ICODE_OVERRUN;
      for (j = 15; j >= 0; j--)
        if (b[j])
          ic = 7'(j);
      if (f[2])
        ic = ICODE_WAKE;
      if (f[3])
        ic = ICODE_ERROR;
      rd(ADDR_INTCODE, {RESP_OKAY, 20'h0, r[11:8], 1'b0, ic});
    end
    frameLen <= 8'd40;
    frameGo <= 1'b1;
    @(posedge core_clk);
    frameGo <= 1'b0;
    repeat (20) @(posedge core_clk);
    req = 3'h0;
    wr(ADDR_MODE_CTRL, modeWord(), RESP_OKAY);
    rd(ADDR_MODE_CTRL, {RESP_OKAY, modeWord()});
    repeat (240) @(posedge core_clk);
    stat = 3'h0;
    rd(ADDR_MODE_CTRL, {RESP_OKAY, modeWord()});
    check({33'h0, txPinOe_n}, 34'h0);
    wr(ADDR_NETFILT, 32'h0, RESP_SLVERR);
    rd(ADDR_NETFILT, {RESP_OKAY, 27'h0, v});
    wr(ADDR_MODE_CTRL, 32'h0, RESP_OKAY);
    window_select_bit = 1'b0;
    rd(ADDR_MODE_CTRL, {RESP_OKAY, modeWord()});
    wr(ADDR_MODE_CTRL, 32'h500, RESP_OKAY);
    repeat (60) @(posedge core_clk);
    check({33'h0, txPinOe_n}, 34'h0);
    for (i = 0; i < 4; i++)
    begin
      setMode(codes[i]);
      check({33'h0, txPinOe_n}, 34'h1);
      check({33'h0, rxPinOwned}, {33'h0, codes[i][0] & codes[i][1]});
      check({33'h0, listenAll}, {33'h0, codes[i][2]});
      engineTx <= 1'($random(seed));
      repeat (3) @(posedge core_clk);
      if (codes[i] == 3'h2)
        check({33'h0, engineRx}, {33'h0, engineTx});
    end
    txBusy <= 1'b1;
    req = 3'h4;
    wr(ADDR_MODE_CTRL, modeWord(), RESP_OKAY);
    repeat (60) @(posedge core_clk);
    rd(ADDR_MODE_CTRL, {RESP_OKAY, modeWord()});
    txBusy <= 1'b0;
    repeat (60) @(posedge core_clk);
    stat = 3'h4;
    rd(ADDR_MODE_CTRL, {RESP_OKAY, modeWord()});
    check({33'h0, wakes == 0}, 34'h1);
    cpuSleep <= 1'b1;
    frameLen <= 8'd4;
    frameGo <= 1'b1;
    @(posedge core_clk);
    frameGo <= 1'b0;
    repeat (40) @(posedge core_clk);
    check({33'h0, wakes != 0}, 34'h1);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
